/* File: rtl/sdfec_consts.svh */
// register offsets, field positions and numeric constants of the fec core
`ifndef SDFEC_CONSTS_SVH
`define SDFEC_CONSTS_SVH
// ************************************************************
// register map, byte addresses
// ************************************************************
`define SDFEC_A_NORM 12'h000
`define SDFEC_A_TSCALE 12'h004
`define SDFEC_A_STATUS 12'h008
`define SDFEC_TBL_PAGE 3'h1
`define SDFEC_S_BUSY 0
`define SDFEC_S_ERRIT 1
`define SDFEC_S_ERRMD 2
`define SDFEC_S_LAST 8:3
`define SDFEC_S_EARLY 9
`define SDFEC_T_N 3:0
`define SDFEC_T_K 7:4
`define SDFEC_T_ENC 8
// ************************************************************
// control word fields and codes
// ************************************************************
`define SDFEC_C_MODE 1:0
`define SDFEC_C_IDX 8:2
`define SDFEC_C_ITER 14:9
`define SDFEC_C_ETCHK 15
`define SDFEC_C_ETSAME 16
`define SDFEC_C_HARD 17
`define SDFEC_C_PAR0 18
`define SDFEC_C_PAR1 19
`define SDFEC_C_ALG 21:20
`define SDFEC_M_LDEC 2'h0
`define SDFEC_M_LENC 2'h1
`define SDFEC_M_TDEC 2'h2
`define SDFEC_M_TENC 2'h3
`define SDFEC_ALG_MAX 2'h0
`define SDFEC_ALG_SCALE 2'h1
`define SDFEC_ALG_STAR 2'h2
`define SDFEC_ALG_BAD 2'h3
`define SDFEC_ITER_NONE 6'h00
// ************************************************************
// datapath numbers
// ************************************************************
`define SDFEC_MAXN 16
`define SDFEC_NCODES 128
`define SDFEC_LLR6_MSB 5
`define SDFEC_SIGN 7
`define SDFEC_FRAC 4
`define SDFEC_UNITY 5'h10
`define SDFEC_SAT_HI 11'sh07f
`define SDFEC_SAT_LO 11'sh781
`define SDFEC_LLR_MAX 8'h7f
`define SDFEC_LLR_MIN 8'h81
`endif

/* File: rtl/sdfec_pkg.sv */
// types shared by the fec core modules
`include "sdfec_consts.svh"
package sdfec_pkg;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_LOAD = 4'h2,
        ST_ITER = 4'h4,
        ST_OUT = 4'h8
    } sdfec_state_t;
    typedef struct packed {
        logic [1:0] mode;
        logic [3:0] n1;
        logic [3:0] k1;
        logic [5:0] iters;
        logic et_chk;
        logic et_same;
        logic hard;
        logic par0;
        logic par1;
        logic [1:0] alg;
    } sdfec_cfg_t;
    typedef logic [`SDFEC_MAXN-1:0][7:0] sdfec_llrs_t;
endpackage : sdfec_pkg

/* File: rtl/sdfec_cfg_if.sv */
// control word and decoded codeword settings between core and decoder
`timescale 1ns/100ps
interface sdfec_cfg_if;
    logic [31:0] word;
    logic [8:0] entry;
    sdfec_pkg::sdfec_cfg_t cfg;
    logic ok;
    logic err_iter;
    logic err_mode;
    modport dec (input word, input entry, output cfg, output ok, output err_iter, output err_mode);
    modport core (output word, output entry, input cfg, input ok, input err_iter, input err_mode);
endinterface : sdfec_cfg_if

/* File: rtl/sdfec_ctrl_dec.sv */
// decoder and checker of the per codeword control word
`timescale 1ns/100ps
`include "sdfec_consts.svh"
module sdfec_ctrl_dec (
    sdfec_cfg_if.dec cif
);
    // ************************************************************
    // field split and refusal of unsupported requests
    // ************************************************************
    always_comb
    begin
        cif.cfg.mode = cif.word[`SDFEC_C_MODE];
        cif.cfg.n1 = cif.entry[`SDFEC_T_N];
        cif.cfg.k1 = cif.entry[`SDFEC_T_K];
        cif.cfg.iters = cif.word[`SDFEC_C_ITER];
        cif.cfg.et_chk = cif.word[`SDFEC_C_ETCHK];
        cif.cfg.et_same = cif.word[`SDFEC_C_ETSAME];
        cif.cfg.hard = cif.word[`SDFEC_C_HARD];
        cif.cfg.par0 = cif.word[`SDFEC_C_PAR0];
        cif.cfg.par1 = cif.word[`SDFEC_C_PAR1];
        cif.cfg.alg = cif.word[`SDFEC_C_ALG];
        // zero iterations is outside 1..63; the 6-bit field caps the top
        cif.err_iter = cif.cfg.mode != `SDFEC_M_LENC && cif.cfg.iters == `SDFEC_ITER_NONE; // R6 R11
        cif.err_mode = cif.cfg.mode == `SDFEC_M_TENC // R1
            || (cif.cfg.mode == `SDFEC_M_TDEC && cif.cfg.alg == `SDFEC_ALG_BAD) // R9
            || (cif.cfg.mode == `SDFEC_M_LENC && !cif.entry[`SDFEC_T_ENC]); // R4
        cif.ok = !cif.err_iter && !cif.err_mode;
    end
endmodule : sdfec_ctrl_dec

/* File: rtl/sdfec_iter.sv */
// one scaled min-sum style iteration over the whole codeword, one cycle
`timescale 1ns/100ps
`include "sdfec_consts.svh"
module sdfec_iter (
    input logic [`SDFEC_MAXN-1:0][7:0] llr_i,
    input logic [3:0] n1_i,
    input logic [4:0] fac_i,
    input logic star_i,
    output logic [`SDFEC_MAXN-1:0][7:0] llr_o,
    output logic pass_o,
    output logic same_o
);
    logic [`SDFEC_MAXN-1:0] hard;
    logic [`SDFEC_MAXN-1:0] old;
    logic [`SDFEC_MAXN-1:0] mask;
    // ************************************************************
    // per position update, factor in sixteenths
    // ************************************************************
    for (genvar g = 0; g < `SDFEC_MAXN; g++)
    begin : g_cell
        logic signed [13:0] prod;
        logic signed [10:0] sum;
        logic [10:0] bias;
        // scaled extrinsic term, factor 1..16 means 0.0625..1
        assign prod = $signed(llr_i[g]) * $signed({1'b0, fac_i}); // R5 R10
        // star correction pushes one step away from zero
        assign bias = !star_i ? 11'h000 : (llr_i[g][`SDFEC_SIGN] ? 11'h7ff : 11'h001); // R9
        assign sum = 11'(signed'(llr_i[g])) + 11'(prod >>> `SDFEC_FRAC) + bias;
        // symmetric saturation keeps -128 out of the soft output
        assign llr_o[g] = (sum > `SDFEC_SAT_HI) ? `SDFEC_LLR_MAX :
            (sum < `SDFEC_SAT_LO) ? `SDFEC_LLR_MIN : sum[7:0];
        assign hard[g] = llr_o[g][`SDFEC_SIGN];
        assign old[g] = llr_i[g][`SDFEC_SIGN];
        assign mask[g] = (4'(g) <= n1_i);
    end
    // check and unchanged flags over the valid length only
    assign pass_o = ~^(hard & mask); // R7 R12
    assign same_o = ((hard ^ old) & mask) == '0; // R7 R12
endmodule : sdfec_iter

/* File: rtl/sdfec_top.sv */
// soft decision fec core: wishbone registers, code table, stream datapath
// Function
// [R1] ldpc encode and decode, turbo decode only
// [R2] code definitions written over the register port
// [R3] code table holds up to 128 codes
// [R4] code chosen per block, encoder reuses table
// [R5] ldpc normalization 0.0625 to 1, sixteenths
// [R6] ldpc iterations 1 to 63, never exceeded
// [R7] ldpc early stop: parity pass, unchanged
// [R8] ldpc 6-bit in, soft 8-bit or hard out
// [R9] turbo algorithms max, max scale, max star
// [R10] turbo scale 0.0625 to 1, sixteenths
// [R11] requester gives turbo iterations 1 to 63
// [R12] turbo early stop: check pass, unchanged
// [R13] turbo 8-bit in, soft or hard, parities optional
// [R14] settings captured at codeword start; norm and tscale are read live from their registers, not captured
//
// Register access over Wishbone and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "sdfec_consts.svh"
module sdfec_top (
    input logic clk_i,
    input logic rst_i,
    input logic wb_cyc_i,
    input logic wb_stb_i,
    input logic wb_we_i,
    input logic [11:0] wb_adr_i,
    input logic [3:0] wb_sel_i,
    input logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input logic ctl_tvalid_i,
    output logic ctl_tready_o,
    input logic [31:0] ctl_tdata_i,
    input logic din_tvalid_i,
    output logic din_tready_o,
    input logic [7:0] din_tdata_i,
    output logic dout_tvalid_o,
    input logic dout_tready_i,
    output logic [7:0] dout_tdata_o,
    output logic dout_tlast_o
);
    // ************************************************************
    // state and helpers
    // ************************************************************
    typedef struct packed {
        sdfec_pkg::sdfec_state_t fsm;
        sdfec_pkg::sdfec_cfg_t cfg;
        sdfec_pkg::sdfec_llrs_t llr;
        logic [3:0] cnt;
        logic [5:0] it;
        logic [3:0] idx;
        logic ov;
        logic ol;
        logic [7:0] od;
        logic [3:0] norm;
        logic [3:0] tscale;
        logic err_it;
        logic err_md;
        logic [5:0] last_it;
        logic last_early;
        logic ack;
        logic [31:0] rdat;
        logic [`SDFEC_NCODES-1:0][8:0] tbl;
    } sdfec_st_t;
    sdfec_st_t st;
    sdfec_st_t next_st;
    sdfec_cfg_if cif ();
    sdfec_pkg::sdfec_llrs_t upd;
    logic pass;
    logic same;
    logic [4:0] fac;
    logic star;
    logic req;
    logic tbl_hit;
    logic [6:0] tbl_idx;
    logic [8:0] tbl_wd;
    logic [31:0] rd;
    logic [31:0] clr;
    logic set_it;
    logic set_md;
    logic [7:0] load_val;
    logic [3:0] load_lim;
    logic [7:0] out_val;
    logic [5:0] it1;
    logic full;
    logic early;
    // byte lane merge for partial wishbone writes
    function automatic logic [31:0] sdfec_wmerge(input logic [31:0] old, input logic [31:0] wd,
        input logic [3:0] sel);
        sdfec_wmerge = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                sdfec_wmerge[b*8 +: 8] = wd[b*8 +: 8];
    endfunction : sdfec_wmerge
    // which positions go out: info always, parity sections on request, every position when encoding
    function automatic logic sdfec_incl(input sdfec_pkg::sdfec_cfg_t c, input logic [3:0] i);
        logic [3:0] p1s;
        p1s = 4'(c.k1 + 4'h1 + ((c.n1 - c.k1) >> 1));
        if (i > c.n1)
            sdfec_incl = 1'b0;
        else if (i <= c.k1 || c.mode == `SDFEC_M_LENC)
            sdfec_incl = 1'b1;
        else if (c.mode == `SDFEC_M_LDEC)
            sdfec_incl = c.par0; // R8
        else
            sdfec_incl = (i < p1s) ? c.par0 : c.par1; // R13
    endfunction : sdfec_incl
    // last included position marks the end of the output codeword
    function automatic logic sdfec_is_last(input sdfec_pkg::sdfec_cfg_t c, input logic [3:0] i);
        sdfec_is_last = 1'b1;
        for (int j = 0; j < `SDFEC_MAXN; j++)
            if (4'(j) > i && sdfec_incl(c, 4'(j)))
                sdfec_is_last = 1'b0;
    endfunction : sdfec_is_last
    // accumulate style parity: a running xor over the information bits
    function automatic logic sdfec_enc_bit(input sdfec_pkg::sdfec_llrs_t v,
        input sdfec_pkg::sdfec_cfg_t c, input logic [3:0] i);
        logic [3:0] lim;
        lim = 4'(i - c.k1 - 4'h1);
        sdfec_enc_bit = 1'b0;
        if (i <= c.k1)
            sdfec_enc_bit = v[i][0];
        else
            for (int j = 0; j < `SDFEC_MAXN; j++)
                if (4'(j) <= c.k1 && 4'(j) <= lim)
                    sdfec_enc_bit = sdfec_enc_bit ^ v[j][0];
    endfunction : sdfec_enc_bit
    // ************************************************************
    // submodules
    // ************************************************************
    assign cif.word = ctl_tdata_i;
    assign cif.entry = st.tbl[ctl_tdata_i[`SDFEC_C_IDX]]; // R4
    sdfec_ctrl_dec u_dec (
        .cif(cif)
    );
    // ldpc uses the programmed normalization, turbo the scale or unity
    always_comb
    begin
        if (st.cfg.mode == `SDFEC_M_LDEC)
            fac = 5'(st.norm) + 5'h01; // R5
        else if (st.cfg.alg == `SDFEC_ALG_SCALE)
            fac = 5'(st.tscale) + 5'h01; // R10
        else
            fac = `SDFEC_UNITY; // R9
        star = st.cfg.mode == `SDFEC_M_TDEC && st.cfg.alg == `SDFEC_ALG_STAR;
    end
    sdfec_iter u_iter (
        .llr_i(st.llr),
        .n1_i(st.cfg.n1),
        .fac_i(fac),
        .star_i(star),
        .llr_o(upd),
        .pass_o(pass),
        .same_o(same)
    );
    // ************************************************************
    // wishbone decode and read mux
    // ************************************************************
    assign req = wb_cyc_i && wb_stb_i;
    assign tbl_hit = wb_adr_i[11:9] == `SDFEC_TBL_PAGE && wb_adr_i[1:0] == 2'h0; // R3
    assign tbl_idx = wb_adr_i[8:2];
    assign tbl_wd = wb_dat_i[8:0];
    // unmapped or unaligned addresses answer with zero
    always_comb
    begin
        rd = 32'h0;
        if (wb_adr_i == `SDFEC_A_NORM)
            rd[3:0] = st.norm;
        else if (wb_adr_i == `SDFEC_A_TSCALE)
            rd[3:0] = st.tscale;
        else if (wb_adr_i == `SDFEC_A_STATUS)
        begin
            rd[`SDFEC_S_BUSY] = st.fsm != sdfec_pkg::ST_IDLE;
            rd[`SDFEC_S_ERRIT] = st.err_it;
            rd[`SDFEC_S_ERRMD] = st.err_md;
            rd[`SDFEC_S_LAST] = st.last_it;
            rd[`SDFEC_S_EARLY] = st.last_early;
        end
        else if (tbl_hit)
            rd[8:0] = st.tbl[tbl_idx];
    end

    // ************************************************************
    // datapath helpers
    // ************************************************************
    // input width depends on mode: 6-bit ldpc soft, 8-bit turbo, bits to encode
    always_comb
    begin
        case (st.cfg.mode)
            `SDFEC_M_LDEC: load_val = {{2{din_tdata_i[`SDFEC_LLR6_MSB]}},
                din_tdata_i[`SDFEC_LLR6_MSB:0]}; // R8
            `SDFEC_M_LENC: load_val = {7'h0, din_tdata_i[0]}; // R1
            default: load_val = din_tdata_i; // R13
        endcase
        load_lim = (st.cfg.mode == `SDFEC_M_LENC) ? st.cfg.k1 : st.cfg.n1;
        if (st.cfg.mode == `SDFEC_M_LENC)
            out_val = {7'h0, sdfec_enc_bit(st.llr, st.cfg, st.idx)};
        else if (st.cfg.hard)
            out_val = {7'h0, st.llr[st.idx][`SDFEC_SIGN]}; // R8 R13
        else
            out_val = st.llr[st.idx];
        it1 = 6'(st.it + 6'h01);
        full = it1 == st.cfg.iters; // R6
        early = (st.cfg.et_chk && pass) || (st.cfg.et_same && same); // R7 R12
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        next_st = st;
        set_it = 1'b0;
        set_md = 1'b0;
        clr = 32'h0;
        // one cycle answer, write commits on the acknowledged edge
        next_st.ack = req && !st.ack;
        if (req && !st.ack)
            next_st.rdat = rd;
        if (req && st.ack && wb_we_i)
        begin
            if (wb_adr_i == `SDFEC_A_NORM)
                next_st.norm = 4'(sdfec_wmerge({28'h0, st.norm}, wb_dat_i, wb_sel_i));
            else if (wb_adr_i == `SDFEC_A_TSCALE)
                next_st.tscale = 4'(sdfec_wmerge({28'h0, st.tscale}, wb_dat_i, wb_sel_i));
            else if (wb_adr_i == `SDFEC_A_STATUS)
                clr = sdfec_wmerge(32'h0, wb_dat_i, wb_sel_i);
            else if (tbl_hit)
                next_st.tbl[tbl_idx] = 9'(sdfec_wmerge({23'h0, st.tbl[tbl_idx]},
                    wb_dat_i, wb_sel_i)); // R2
        end
        case (st.fsm)
            sdfec_pkg::ST_IDLE:
                if (ctl_tvalid_i)
                begin
                    set_it = cif.err_iter; // R6
                    set_md = cif.err_mode; // R1
                    if (cif.ok)
                    begin
                        next_st.cfg = cif.cfg; // R14
                        next_st.cnt = 4'h0;
                        next_st.fsm = sdfec_pkg::ST_LOAD;
                    end
                end
            sdfec_pkg::ST_LOAD:
                if (din_tvalid_i)
                begin
                    next_st.llr[st.cnt] = load_val;
                    next_st.cnt = 4'(st.cnt + 4'h1);
                    if (st.cnt == load_lim)
                    begin
                        next_st.it = `SDFEC_ITER_NONE;
                        next_st.idx = 4'h0;
                        next_st.ov = 1'b0;
                        // encoding needs no iterations
                        next_st.fsm = (st.cfg.mode == `SDFEC_M_LENC) ?
                            sdfec_pkg::ST_OUT : sdfec_pkg::ST_ITER;
                    end
                end
            sdfec_pkg::ST_ITER:
            begin
                next_st.llr = upd;
                next_st.it = it1;
                if (full || early)
                begin
                    next_st.fsm = sdfec_pkg::ST_OUT; // R6 R7 R12
                    next_st.last_it = it1;
                    next_st.last_early = early;
                end
            end
            sdfec_pkg::ST_OUT:
                // output register refills only when empty or taken
                if (!st.ov || dout_tready_i)
                begin
                    next_st.ov = 1'b0;
                    if (st.ov && st.ol)
                        next_st.fsm = sdfec_pkg::ST_IDLE;
                    else
                    begin
                        if (sdfec_incl(st.cfg, st.idx))
                        begin
                            next_st.ov = 1'b1;
                            next_st.od = out_val;
                            next_st.ol = sdfec_is_last(st.cfg, st.idx);
                        end
                        next_st.idx = 4'(st.idx + 4'h1);
                    end
                end
            default: next_st.fsm = sdfec_pkg::ST_IDLE;
        endcase
        // sticky errors, a new error beats a same cycle clear
        next_st.err_it = (st.err_it & ~clr[`SDFEC_S_ERRIT]) | set_it;
        next_st.err_md = (st.err_md & ~clr[`SDFEC_S_ERRMD]) | set_md;
    end

    // state register, synchronous reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st <= '0;
            st.fsm <= sdfec_pkg::ST_IDLE;
        end
        else
            st <= next_st;
    end
    // ************************************************************
    // outputs
    // ************************************************************
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdat;
    assign ctl_tready_o = st.fsm == sdfec_pkg::ST_IDLE;
    assign din_tready_o = st.fsm == sdfec_pkg::ST_LOAD;
    assign dout_tvalid_o = st.ov;
    assign dout_tdata_o = st.od;
    assign dout_tlast_o = st.ol;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_iter_bound: assert property ( // R6
        st.fsm == sdfec_pkg::ST_ITER |-> st.it < st.cfg.iters)
        else $error("iteration count ran past the requested limit");
    chk_turbo_enc_rej: assert property ( // R1
        ctl_tvalid_i && ctl_tready_o && ctl_tdata_i[`SDFEC_C_MODE] == `SDFEC_M_TENC
        |=> st.fsm == sdfec_pkg::ST_IDLE && st.err_md)
        else $error("turbo encode request was not refused");
    chk_algo_rej: assert property ( // R9
        ctl_tvalid_i && ctl_tready_o && ctl_tdata_i[`SDFEC_C_MODE] == `SDFEC_M_TDEC
        && ctl_tdata_i[`SDFEC_C_ALG] == `SDFEC_ALG_BAD |=> st.fsm == sdfec_pkg::ST_IDLE)
        else $error("undefined turbo algorithm was accepted");
    chk_enc_reuse: assert property ( // R4
        ctl_tvalid_i && ctl_tready_o && ctl_tdata_i[`SDFEC_C_MODE] == `SDFEC_M_LENC
        && !cif.entry[`SDFEC_T_ENC] |=> st.err_md && st.fsm == sdfec_pkg::ST_IDLE)
        else $error("encode accepted with a code not fit for encoding");
    chk_cfg_hold: assert property ( // R14
        st.fsm != sdfec_pkg::ST_IDLE |=> st.fsm == sdfec_pkg::ST_IDLE || $stable(st.cfg))
        else $error("settings changed inside a codeword");
    chk_factor_range: assert property ( // R5 R10
        st.fsm == sdfec_pkg::ST_ITER |-> fac >= 5'h01 && fac <= `SDFEC_UNITY)
        else $error("scale factor outside one to sixteen sixteenths");
    chk_early_stop: assert property ( // R7 R12
        st.fsm == sdfec_pkg::ST_ITER && st.cfg.et_chk && pass
        |=> st.fsm == sdfec_pkg::ST_OUT && st.last_early)
        else $error("enabled check pass did not stop iterating");
    chk_hard_out: assert property ( // R8 R13
        dout_tvalid_o && (st.cfg.hard || st.cfg.mode == `SDFEC_M_LENC)
        |-> dout_tdata_o[7:1] == 7'h00)
        else $error("hard output carries more than one bit");
    chk_wb_ack: assert property (
        req && !st.ack |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone answer not a single cycle after one wait");
    chk_tbl_write: assert property ( // R2 R3
        req && st.ack && wb_we_i && tbl_hit && wb_sel_i == 4'hf
        |=> st.tbl[$past(tbl_idx)] == $past(tbl_wd))
        else $error("code table entry not written");

    cov_early_stop: cover property (
        st.fsm == sdfec_pkg::ST_ITER ##1 st.fsm == sdfec_pkg::ST_OUT && st.last_early);
    cov_full_iters: cover property (
        st.fsm == sdfec_pkg::ST_ITER && full && !early);
    cov_encode_last: cover property (
        dout_tvalid_o && dout_tready_i && dout_tlast_o && st.cfg.mode == `SDFEC_M_LENC);
    cov_turbo_star: cover property (
        st.fsm == sdfec_pkg::ST_ITER && star);
endmodule : sdfec_top

/* File: verif/sdfec_sink.sv */
// output stream sink standing in for the downstream logic
`timescale 1ns/100ps
module sdfec_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic tvalid_i,
    input wire logic [7:0] tdata_i,
    input wire logic tlast_i,
    output logic tready_o
);
    logic [7:0] got [0:63];
    int cnt;
    int last_at;
    // ready toggles while stalling, so every beat must be held across a refusal
    always @(posedge clk_i)
    begin
        tready_o <= rst_i ? 1'b1 : (stall_i ? ~tready_o : 1'b1);
        if (rst_i)
            cnt <= 0;
        else if (tvalid_i && tready_o)
        begin
            got[cnt] <= tdata_i;
            if (tlast_i)
                last_at <= cnt;
            cnt <= cnt + 1;
        end
    end
endmodule : sdfec_sink

/* File: verif/sdfec_top_tb.sv */
// self-checking bench for the fec core
`timescale 1ns/100ps
module sdfec_top_tb;
    logic clk_i = 1'b0, rst_i = 1'b1, stall = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, ctl_tdata_i = 32'h0, rd;
    logic ctl_tvalid_i = 1'b0, ctl_tready_o, din_tvalid_i = 1'b0, din_tready_o;
    logic [7:0] din_tdata_i = 8'h00, dout_tdata_o;
    logic dout_tvalid_o, dout_tready_i, dout_tlast_o;
    int fails = 0, checks_done = 0;
    sdfec_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctl_tvalid_i(ctl_tvalid_i),
        .ctl_tready_o(ctl_tready_o), .ctl_tdata_i(ctl_tdata_i), .din_tvalid_i(din_tvalid_i),
        .din_tready_o(din_tready_o), .din_tdata_i(din_tdata_i), .dout_tvalid_o(dout_tvalid_o),
        .dout_tready_i(dout_tready_i), .dout_tdata_o(dout_tdata_o), .dout_tlast_o(dout_tlast_o));
    sdfec_sink u_sink (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tvalid_i(dout_tvalid_o),
        .tdata_i(dout_tdata_o), .tlast_i(dout_tlast_o), .tready_o(dout_tready_i));
    // ************************************************************
    // clock and helpers
    // ************************************************************
    initial
    begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // classic cycle: hold everything until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (!wb_ack_o);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    function automatic logic [31:0] cw(input logic [1:0] md, input logic [6:0] ix,
        input logic [5:0] it, input logic hd, input logic p0, input logic [1:0] al);
        return {10'h000, al, 1'b0, p0, hd, 2'b00, it, ix, md};
    endfunction : cw
    task automatic send_ctl(input logic [31:0] w);
        ctl_tdata_i <= w;
        ctl_tvalid_i <= 1'b1;
        do @(posedge clk_i); while (!ctl_tready_o);
        ctl_tvalid_i <= 1'b0;
    endtask : send_ctl
    // one codeword of two samples, then two outputs expected with last on the second
    task automatic run_cw(input logic [31:0] w, input logic [7:0] s0, s1, e0, e1);
        int base;
        base = u_sink.cnt;
        send_ctl(w);
        for (int k = 0; k < 2; k++)
        begin
            din_tdata_i <= k ? s1 : s0;
            din_tvalid_i <= 1'b1;
            do @(posedge clk_i); while (!din_tready_o);
        end
        din_tvalid_i <= 1'b0;
        repeat (200) if (u_sink.cnt < base + 2) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        chk(u_sink.cnt - base, 2);
        chk(u_sink.got[base], e0);
        chk(u_sink.got[base + 1], e1);
        chk(u_sink.last_at - base, 1);
    endtask : run_cw
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs;
        wb(1'b1, 12'h000, 32'hf);
        wb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hf);
        // a write with lane 0 disabled must leave the factor alone
        wb_sel_i <= 4'he;
        wb(1'b1, 12'h000, 32'h3);
        wb_sel_i <= 4'hf;
        wb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'hf);
        wb(1'b1, 12'h200 + 12'h00c, 32'h001);
        wb(1'b1, 12'h200 + 12'h1fc, 32'h111);
        wb(1'b0, 12'h3fc, 32'h0);
        chk(rd, 32'h111);
        wb(1'b0, 12'h0f0, 32'h0);
        chk(rd, 32'h0);
    endtask : t_regs
    task automatic t_ldpc;
        // even signs pass the check: stops after one of five iterations
        run_cw(cw(2'h0, 7'd3, 6'd5, 1'b0, 1'b1, 2'h0) | 32'h8000,
            8'h05, 8'h02, 8'h0a, 8'h04);
        wb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h208);
        // factor 16/16 doubles: 5 -> 10, -2 -> -4, parity position included
        run_cw(cw(2'h0, 7'd3, 6'd1, 1'b0, 1'b1, 2'h0), 8'h05, 8'h3e, 8'h0a, 8'hfc);
        wb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h008);
        // encode of a two bit code passes bit 0 of each sample
        run_cw(cw(2'h1, 7'd127, 6'd0, 1'b0, 1'b0, 2'h0), 8'h01, 8'h02, 8'h01, 8'h00);
    endtask : t_ldpc
    task automatic t_refuse;
        send_ctl(cw(2'h3, 7'd127, 6'd1, 1'b0, 1'b0, 2'h0));
        @(posedge clk_i);
        chk(ctl_tready_o, 1);
        send_ctl(cw(2'h1, 7'd3, 6'd1, 1'b0, 1'b0, 2'h0));
        wb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h00c);
        wb(1'b1, 12'h008, 32'h6);
        send_ctl(cw(2'h0, 7'd3, 6'd0, 1'b0, 1'b0, 2'h0));
        wb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h00a);
    endtask : t_refuse
    task automatic t_turbo;
        stall <= 1'b1;
        wb(1'b1, 12'h004, 32'h7);
        // scale 8/16 adds half: 16 -> 24, -32 -> -48
        run_cw(cw(2'h2, 7'd127, 6'd1, 1'b0, 1'b0, 2'h1), 8'h10, 8'he0, 8'h18, 8'hd0);
        for (int a = 0; a < 3; a++)
            run_cw(cw(2'h2, 7'd127, 6'd1, 1'b1, 1'b0, a[1:0]), 8'h10, 8'h90, 8'h00, 8'h01);
        // unchanged hard decisions end the decode after one of nine
        run_cw(cw(2'h2, 7'd127, 6'd9, 1'b1, 1'b0, 2'h0) | 32'h10000,
            8'h10, 8'h90, 8'h00, 8'h01);
        wb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h20a);
        stall <= 1'b0;
    endtask : t_turbo
    // ************************************************************
    // sequence, watchdog and verdict
    // ************************************************************
    task automatic print_verdict;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_ldpc();
        t_refuse();
        t_turbo();
        print_verdict();
    end
    // whole run needs well under a thousand cycles
    initial
    begin
        #(50 * 20000);
        fails++;
        print_verdict();
    end
endmodule : sdfec_top_tb
